// File: verilog/eusi_pkg.sv
package eusi_pkg;
   // Character kinds on the link-side character path
   localparam logic [2:0] EUSI_K_DATA = 3'h0;
   localparam logic [2:0] EUSI_K_EOP = 3'h1;
   localparam logic [2:0] EUSI_K_EEP = 3'h2;
   localparam logic [2:0] EUSI_K_TIME = 3'h3;
   localparam logic [2:0] EUSI_K_INT = 3'h4;
   localparam logic [2:0] EUSI_K_ACK = 3'h5;
   // Field widths
   localparam int EUSI_DATA_W = 8;
   localparam int EUSI_IID_W = 5;
   localparam int EUSI_TIME_W = 6;
   // Receive buffer word layout: {err, end, data}
   localparam int EUSI_BUF_END = 8;
   localparam int EUSI_BUF_ERR = 9;
   localparam int EUSI_BUF_W = 10;
   // Reset values
   localparam logic [7:0] EUSI_RST_DATA = 8'h00;
   localparam logic [2:0] EUSI_RST_KIND = 3'h0;
   localparam logic [5:0] EUSI_RST_TIME = 6'h3F;
   localparam logic [31:0] EUSI_RST_PEND = 32'h0000_0000;
   // Default depth of the receive packet buffer, in characters
   localparam int EUSI_RX_DEPTH = 64;
endpackage : eusi_pkg

// File: verilog/eusi_endpoint.sv
`timescale 1ns/1ps
`default_nettype none
module eusi_endpoint
   import eusi_pkg::*;
#(
   parameter int RX_DEPTH = EUSI_RX_DEPTH,
   parameter logic [7:0] EP_ID = 8'h01, // Arbitrary end-point number
   parameter bit HAS_TIME = 1'b1,
   parameter bit HAS_INT = 1'b1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Packet send request
   input wire logic tx_pkt_valid,
   input wire logic [7:0] tx_pkt_data,
   input wire logic tx_pkt_end,
   input wire logic tx_pkt_err,
   output logic tx_pkt_ready,
   // Packet receive indication and read-out
   output logic rx_pkt_ind,
   output logic rx_rd_valid,
   output logic [7:0] rx_rd_data,
   output logic rx_rd_end,
   output logic rx_rd_err,
   input wire logic rx_rd_ready,
   // Time-code request and indication
   input wire logic tc_req_valid,
   input wire logic [7:0] tc_req_value,
   output logic tc_req_ready,
   output logic tc_ind,
   output logic [7:0] tc_ind_value,
   // Distributed interrupt request, acknowledge and indications
   input wire logic int_req_valid,
   input wire logic [4:0] int_req_id,
   output logic int_req_ready,
   input wire logic ack_req_valid,
   input wire logic [4:0] ack_req_id,
   output logic ack_req_ready,
   output logic int_ind,
   output logic [4:0] int_ind_id,
   output logic ack_ind,
   output logic [4:0] ack_ind_id,
   // Configuration and status
   input wire logic cfg_time_en,
   input wire logic cfg_int_en,
   input wire logic cfg_ack_en,
   input wire logic cfg_loopback,
   output logic [7:0] sts_ep_id,
   output logic [3:0] sts_cfg,
   output logic [31:0] sts_int_pend,
   output logic sts_tx_busy,
   // Link-side character path
   input wire logic lnk_run,
   output logic lnk_tx_valid,
   output logic [2:0] lnk_tx_kind,
   output logic [7:0] lnk_tx_data,
   input wire logic lnk_tx_ready,
   input wire logic lnk_rx_valid,
   input wire logic [2:0] lnk_rx_kind,
   input wire logic [7:0] lnk_rx_data,
   output logic lnk_rx_ready
);
   localparam int AW = $clog2(RX_DEPTH);

   // Depth must be a power of two for the wrapping pointers
   if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_chk
      $error("RX_DEPTH must be a power of two, at least 2");
   end

   // Broadcast codes bypass the packet buffer
   function automatic logic eusi_is_code(input logic [2:0] k);
      eusi_is_code = (k == EUSI_K_TIME) || (k == EUSI_K_INT) || (k == EUSI_K_ACK);
   endfunction : eusi_is_code

   ////////////////////////////////////////////////////////////////////////
   // Transmit side
   logic txv_r;
   logic [2:0] txk_r;
   logic [7:0] txd_r;
   logic tc_p_r;
   logic [7:0] tc_v_r;
   logic int_p_r;
   logic [4:0] int_v_r;
   logic ack_p_r;
   logic [4:0] ack_v_r;
   logic snk_rdy;
   logic slot_free;
   logic tx_allow;
   logic code_p;
   logic pkt_take;
   logic tc_take;
   logic int_take;
   logic ack_take;
   logic rx_acc;
   logic time_on;
   logic int_on;

   // Optional services vanish when their parameter is off
   assign time_on = HAS_TIME & cfg_time_en;
   assign int_on = HAS_INT & cfg_int_en;

   // In loopback the receive path is the sink of the output slot
   assign snk_rdy = cfg_loopback ? rx_acc : lnk_tx_ready;
   assign slot_free = !txv_r || snk_rdy;
   assign tx_allow = lnk_run || cfg_loopback;
   assign code_p = tc_p_r || int_p_r || ack_p_r;
   // Codes win the slot so they never wait behind a packet
   assign tx_pkt_ready = slot_free && tx_allow && !code_p;
   assign pkt_take = tx_pkt_valid && tx_pkt_ready;
   // One request held per service until it enters the slot
   assign tc_req_ready = !tc_p_r && time_on;
   assign int_req_ready = !int_p_r && int_on;
   assign ack_req_ready = !ack_p_r && int_on;
   assign tc_take = tc_req_valid && tc_req_ready;
   assign int_take = int_req_valid && int_req_ready;
   assign ack_take = ack_req_valid && ack_req_ready;

   // Pending broadcast requests
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tc_p_r <= 1'b0;
         int_p_r <= 1'b0;
         ack_p_r <= 1'b0;
         tc_v_r <= EUSI_RST_DATA;
         int_v_r <= 5'h00;
         ack_v_r <= 5'h00;
      end else begin
         if (tc_take) begin
            tc_p_r <= 1'b1;
            tc_v_r <= tc_req_value;
         end else if (slot_free && tx_allow && !int_p_r && !ack_p_r) begin
            tc_p_r <= 1'b0;
         end
         if (int_take) begin
            int_p_r <= 1'b1;
            int_v_r <= int_req_id;
         end else if (slot_free && tx_allow) begin
            int_p_r <= 1'b0;
         end
         if (ack_take) begin
            ack_p_r <= cfg_ack_en;
            ack_v_r <= ack_req_id;
         end else if (slot_free && tx_allow && !int_p_r) begin
            ack_p_r <= 1'b0;
         end
      end
   end

   // Output slot: interrupt, then ack, then time, then packet
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txv_r <= 1'b0;
         txk_r <= EUSI_RST_KIND;
         txd_r <= EUSI_RST_DATA;
      end else if (slot_free) begin
         txv_r <= 1'b0;
         if (tx_allow && int_p_r) begin
            txv_r <= 1'b1;
            txk_r <= EUSI_K_INT;
            txd_r <= {3'h0, int_v_r};
         end else if (tx_allow && ack_p_r) begin
            txv_r <= 1'b1;
            txk_r <= EUSI_K_ACK;
            txd_r <= {3'h0, ack_v_r};
         end else if (tx_allow && tc_p_r) begin
            txv_r <= 1'b1;
            txk_r <= EUSI_K_TIME;
            txd_r <= tc_v_r;
         end else if (pkt_take) begin
            txv_r <= 1'b1;
            txk_r <= !tx_pkt_end ? EUSI_K_DATA : (tx_pkt_err ? EUSI_K_EEP : EUSI_K_EOP);
            txd_r <= tx_pkt_end ? EUSI_RST_DATA : tx_pkt_data;
         end
      end
   end

   // Link driven only when not looped back
   assign lnk_tx_valid = txv_r && !cfg_loopback;
   assign lnk_tx_kind = txk_r;
   assign lnk_tx_data = txd_r;

   ////////////////////////////////////////////////////////////////////////
   // Receive side
   logic in_v;
   logic [2:0] in_k;
   logic [7:0] in_d;
   logic in_take;
   logic [EUSI_BUF_W-1:0] mem_r [RX_DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   logic [AW:0] pkt_cnt_r;
   logic buf_full;
   logic wr_en;
   logic wr_end;
   logic rd_take;
   logic rd_end;
   logic [EUSI_BUF_W-1:0] head;
   logic [5:0] tc_last_r;
   logic tc_good;
   logic int_good;
   logic ack_good;
   logic [31:0] int_pend_r;

   assign in_v = cfg_loopback ? txv_r : lnk_rx_valid;
   assign in_k = cfg_loopback ? txk_r : lnk_rx_kind;
   assign in_d = cfg_loopback ? txd_r : lnk_rx_data;
   assign buf_full = (wr_r - rd_r) == (AW + 1)'(RX_DEPTH);
   // Codes are always consumed; packet characters stall on a full buffer
   assign rx_acc = eusi_is_code(in_k) || !buf_full;
   assign lnk_rx_ready = rx_acc && !cfg_loopback;
   assign in_take = in_v && rx_acc;
   assign wr_en = in_take && !eusi_is_code(in_k);
   assign wr_end = wr_en && (in_k != EUSI_K_DATA);

   // Packet buffer write, whole packets kept until read
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem_r[wr_r[AW-1:0]] <= {in_k == EUSI_K_EEP, in_k != EUSI_K_DATA, in_d};
      end
   end

   // Only complete packets are offered, so a read never waits mid-packet
   assign head = mem_r[rd_r[AW-1:0]];
   assign rx_rd_valid = pkt_cnt_r != '0;
   assign rx_rd_data = head[EUSI_DATA_W-1:0];
   assign rx_rd_end = head[EUSI_BUF_END];
   assign rx_rd_err = head[EUSI_BUF_ERR];
   assign rd_take = rx_rd_valid && rx_rd_ready;
   assign rd_end = rd_take && head[EUSI_BUF_END];
   assign rx_pkt_ind = pkt_cnt_r != '0;

   // Pointers and count of complete packets
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_r <= '0;
         rd_r <= '0;
         pkt_cnt_r <= '0;
      end else begin
         if (wr_en) begin
            wr_r <= wr_r + 1'b1;
         end
         if (rd_take) begin
            rd_r <= rd_r + 1'b1;
         end
         if (wr_end && !rd_end) begin
            pkt_cnt_r <= pkt_cnt_r + 1'b1;
         end else if (rd_end && !wr_end) begin
            pkt_cnt_r <= pkt_cnt_r - 1'b1;
         end
      end
   end

   // A time-code is valid when its count follows the last one
   assign tc_good = in_take && in_k == EUSI_K_TIME && time_on
      && in_d[5:0] == tc_last_r + 6'h01;
   assign int_good = in_take && in_k == EUSI_K_INT && int_on
      && !int_pend_r[in_d[4:0]];
   assign ack_good = in_take && in_k == EUSI_K_ACK && int_on;

   // Indications are one-cycle pulses with registered values
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tc_ind <= 1'b0;
         int_ind <= 1'b0;
         ack_ind <= 1'b0;
         tc_ind_value <= EUSI_RST_DATA;
         int_ind_id <= 5'h00;
         ack_ind_id <= 5'h00;
         tc_last_r <= EUSI_RST_TIME;
      end else begin
         tc_ind <= tc_good;
         int_ind <= int_good;
         ack_ind <= ack_good;
         if (in_take && in_k == EUSI_K_TIME && time_on) begin
            tc_last_r <= in_d[5:0];
         end
         if (tc_good) begin
            tc_ind_value <= in_d;
         end
         if (int_good) begin
            int_ind_id <= in_d[4:0];
         end
         if (ack_good) begin
            ack_ind_id <= in_d[4:0];
         end
      end
   end

   // Pending interrupts; a new arrival beats a clear of the same bit
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         int_pend_r <= EUSI_RST_PEND;
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (int_good && in_d[4:0] == 5'(i)) begin
               int_pend_r[i] <= 1'b1;
            end else if ((ack_take && ack_req_id == 5'(i))
                  || (ack_good && in_d[4:0] == 5'(i))) begin
               int_pend_r[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status read-back
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sts_cfg <= 4'h0;
         sts_tx_busy <= 1'b0;
      end else begin
         sts_cfg <= {cfg_loopback, cfg_ack_en, cfg_int_en, cfg_time_en};
         sts_tx_busy <= txv_r || code_p;
      end
   end
   assign sts_int_pend = int_pend_r;
   assign sts_ep_id = EP_ID;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_PKT_SENT: assert property (pkt_take |=> txv_r && txk_r == $past(tx_pkt_end ?
      (tx_pkt_err ? EUSI_K_EEP : EUSI_K_EOP) : EUSI_K_DATA))
      else $error("packet character not loaded");
   AST_RUN_ONLY: assert property (pkt_take |-> lnk_run || cfg_loopback)
      else $error("packet character taken while link down");
   AST_RX_HOLD: assert property (rx_pkt_ind && !rd_end |=> rx_pkt_ind)
      else $error("held packet lost before read");
   AST_RX_IND: assert property (wr_end |=> rx_pkt_ind)
      else $error("completed packet not indicated");
   AST_INT_NOW: assert property (int_p_r && slot_free && tx_allow
      |=> txv_r && txk_r == EUSI_K_INT)
      else $error("interrupt code delayed");
   AST_TC_OUT: assert property (tc_take && !int_p_r && !ack_p_r && !txv_r && !pkt_take
      ##1 !int_p_r && !ack_p_r && tx_allow |=> txv_r && txk_r == EUSI_K_TIME)
      else $error("time-code not sent");
   AST_TC_IND: assert property (tc_ind |-> $past(in_take) && $past(in_k) == EUSI_K_TIME
      && $past(time_on))
      else $error("time-code indication without valid code");
   AST_INT_IND: assert property (int_ind |-> $past(in_k) == EUSI_K_INT
      && int_pend_r[int_ind_id])
      else $error("interrupt indication without valid code");
   AST_ACK_IND: assert property (ack_ind |-> $past(in_take && in_k == EUSI_K_ACK))
      else $error("ack indication without valid code");
   AST_ACK_CLR: assert property (ack_take && !int_good |=> !int_pend_r[$past(ack_req_id)])
      else $error("acknowledge did not clear pending interrupt");
   AST_ONE_TC: assert property (tc_p_r |-> !tc_req_ready)
      else $error("second time-code accepted");
   AST_LOOP_QUIET: assert property (cfg_loopback |-> !lnk_tx_valid)
      else $error("link driven in loopback");

   COV_PKT_RT: cover property (pkt_take && tx_pkt_end ##[1:20] rx_pkt_ind);
   COV_TC_IND: cover property (tc_ind);
   COV_INT_ACK: cover property (int_ind ##[1:50] ack_take);
   COV_CODE_CUT: cover property (txv_r && txk_r == EUSI_K_DATA ##1 txk_r == EUSI_K_INT);

endmodule : eusi_endpoint
`default_nettype wire

// File: dv/eusi_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module eusi_link_model (
   // Clock
   input wire logic clk_sys,
   // Characters leaving the end-point
   input wire logic lnk_tx_valid,
   input wire logic [2:0] lnk_tx_kind,
   input wire logic [7:0] lnk_tx_data,
   output logic lnk_tx_ready,
   // Characters arriving at the end-point
   output logic lnk_run,
   output logic lnk_rx_valid,
   output logic [2:0] lnk_rx_kind,
   output logic [7:0] lnk_rx_data,
   input wire logic lnk_rx_ready
);
   logic [10:0] got_q[$];
   bit slow = 1'b0;
   int unsigned cnt = 0;
   initial begin
      lnk_tx_ready = 1'b0;
      lnk_run = 1'b1;
      lnk_rx_valid = 1'b0;
      lnk_rx_kind = 3'h0;
      lnk_rx_data = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Collect sent characters; slow mode takes one in three to stress holding
   always @(posedge clk_sys) begin
      if (lnk_tx_valid === 1'b1 && lnk_tx_ready === 1'b1) begin
         got_q.push_back({lnk_tx_kind, lnk_tx_data});
      end
      cnt <= cnt + 1;
      lnk_tx_ready <= #1 !slow || (cnt % 3 == 0);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Offer one character, hold until taken, then scramble the idle lines
   task automatic send_char(input logic [2:0] k, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      lnk_rx_valid = 1'b1;
      lnk_rx_kind = k;
      lnk_rx_data = d;
      do @(negedge clk_sys); while (lnk_rx_ready !== 1'b1);
      @(posedge clk_sys);
      #1;
      lnk_rx_valid = 1'b0;
      lnk_rx_kind = ~k;
      lnk_rx_data = ~d;
   endtask : send_char
endmodule : eusi_link_model
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import eusi_pkg::*; ;
   logic clk_sys, rst, tx_pkt_valid, tx_pkt_end, tx_pkt_err, rx_rd_ready, tc_req_valid;
   logic int_req_valid, ack_req_valid, cfg_time_en, cfg_int_en, cfg_ack_en, cfg_loopback;
   logic tx_pkt_ready, rx_pkt_ind, rx_rd_valid, rx_rd_end, rx_rd_err, tc_req_ready, tc_ind;
   logic int_req_ready, ack_req_ready, int_ind, ack_ind, sts_tx_busy, lnk_run, lnk_tx_valid;
   logic lnk_tx_ready, lnk_rx_valid, lnk_rx_ready;
   logic [7:0] tx_pkt_data, tc_req_value, rx_rd_data, tc_ind_value, sts_ep_id, lnk_tx_data;
   logic [7:0] lnk_rx_data;
   logic [4:0] int_req_id, ack_req_id, int_ind_id, ack_ind_id;
   logic [3:0] sts_cfg;
   logic [31:0] sts_int_pend, seed = 32'h3D6F25EB, r;
   logic [2:0] lnk_tx_kind, lnk_rx_kind;
   logic [10:0] exp_q[$];
   logic [9:0] rx_exp[$], ind_q[$], ind_exp[$];
   int fail_count = 0, total_checks = 0, cyc = 0, last = 63;
   int vals[3] = '{0, 5, 6};
   logic [4:0] id;

   eusi_endpoint #(.RX_DEPTH(4)) DUT (.clk_sys, .rst, .tx_pkt_valid, .tx_pkt_data, .tx_pkt_end,
      .tx_pkt_err, .tx_pkt_ready, .rx_pkt_ind, .rx_rd_valid, .rx_rd_data, .rx_rd_end, .rx_rd_err,
      .rx_rd_ready, .tc_req_valid, .tc_req_value, .tc_req_ready, .tc_ind, .tc_ind_value,
      .int_req_valid, .int_req_id, .int_req_ready, .ack_req_valid, .ack_req_id, .ack_req_ready,
      .int_ind, .int_ind_id, .ack_ind, .ack_ind_id, .cfg_time_en, .cfg_int_en, .cfg_ack_en,
      .cfg_loopback, .sts_ep_id, .sts_cfg, .sts_int_pend, .sts_tx_busy, .lnk_run, .lnk_tx_valid,
      .lnk_tx_kind, .lnk_tx_data, .lnk_tx_ready, .lnk_rx_valid, .lnk_rx_kind, .lnk_rx_data,
      .lnk_rx_ready);
   eusi_link_model m (.clk_sys, .lnk_tx_valid, .lnk_tx_kind, .lnk_tx_data, .lnk_tx_ready,
      .lnk_run, .lnk_rx_valid, .lnk_rx_kind, .lnk_rx_data, .lnk_rx_ready);
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, hang guard and indication monitor (pulses sampled mid-cycle)
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   always @(negedge clk_sys) begin
      if (tc_ind === 1'b1) ind_q.push_back({2'd1, tc_ind_value});
      if (int_ind === 1'b1) ind_q.push_back({2'd2, 3'h0, int_ind_id});
      if (ack_ind === 1'b1) ind_q.push_back({2'd3, 3'h0, ack_ind_id});
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   // One request on service s, held until its ready is seen at an edge
   task automatic req(input int s, input logic [7:0] v, input logic [1:0] e);
      // Let an edge pass so a lowered valid is never raised in the same step
      @(posedge clk_sys);
      #1;
      case (s)
         0: begin
            tx_pkt_valid = 1'b1;
            tx_pkt_data = v;
            {tx_pkt_err, tx_pkt_end} = e;
         end
         1: begin
            tc_req_valid = 1'b1;
            tc_req_value = v;
         end
         2: begin
            int_req_valid = 1'b1;
            int_req_id = v[4:0];
         end
         default: begin
            ack_req_valid = 1'b1;
            ack_req_id = v[4:0];
         end
      endcase
      do @(negedge clk_sys); while ((s == 0 ? tx_pkt_ready : s == 1 ? tc_req_ready :
         s == 2 ? int_req_ready : ack_req_ready) !== 1'b1);
      @(posedge clk_sys);
      #1;
      {tx_pkt_valid, tc_req_valid, int_req_valid, ack_req_valid} = 4'h0;
   endtask : req
   // Busy flag lags a cycle, so let the launch settle before waiting on it
   task automatic drain();
      logic [10:0] g;
      logic [10:0] x;
      repeat (3) @(negedge clk_sys);
      while (sts_tx_busy !== 1'b0 || lnk_tx_valid !== 1'b0) @(negedge clk_sys);
      check(16'(m.got_q.size()), 16'(exp_q.size()));
      while (exp_q.size() > 0 && m.got_q.size() > 0) begin
         g = m.got_q.pop_front();
         x = exp_q.pop_front();
         if (x[10:8] inside {EUSI_K_EOP, EUSI_K_EEP}) g[7:0] = 8'h00;
         check({5'h0, g}, {5'h0, x});
      end
      exp_q.delete();
      m.got_q.delete();
   endtask : drain
   task automatic ind_cmp();
      repeat (3) @(negedge clk_sys);
      check(16'(ind_q.size()), 16'(ind_exp.size()));
      while (ind_exp.size() > 0 && ind_q.size() > 0) begin
         check({6'h0, ind_q.pop_front()}, {6'h0, ind_exp.pop_front()});
      end
      ind_q.delete();
      ind_exp.delete();
   endtask : ind_cmp
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {tx_pkt_valid, tx_pkt_end, tx_pkt_err, rx_rd_ready, tc_req_valid} = 5'h00;
      {int_req_valid, ack_req_valid, cfg_loopback} = 3'h0;
      {cfg_time_en, cfg_int_en, cfg_ack_en} = 3'h7;
      {tx_pkt_data, tc_req_value, int_req_id, ack_req_id} = 26'h0;
      rst = 1'b1;
      repeat (20) @(posedge clk_sys);
      #1 rst = 1'b0;
      check({8'h0, sts_ep_id}, 16'h0001);
      // Config read-back is registered, one cycle behind the inputs
      repeat (2) @(negedge clk_sys);
      check({12'h0, sts_cfg}, 16'h0007);
      // Packet out against a stalling link, random end marker
      m.slow = 1'b1;
      repeat (3) begin
         r = rnd();
         req(0, r[7:0], 2'b00);
         exp_q.push_back({EUSI_K_DATA, r[7:0]});
      end
      r = rnd();
      req(0, 8'h00, {r[0], 1'b1});
      exp_q.push_back({r[0] ? EUSI_K_EEP : EUSI_K_EOP, 8'h00});
      drain();
      m.slow = 1'b0;
      // Broadcast requests: time-code, interrupt
      r = rnd();
      req(1, r[7:0], 2'b00);
      exp_q.push_back({EUSI_K_TIME, r[7:0]});
      drain();
      r = rnd();
      req(2, {3'h0, r[4:0]}, 2'b00);
      exp_q.push_back({EUSI_K_INT, 3'h0, r[4:0]});
      drain();
      // Packet in ending in an error marker, held then read out
      repeat (3) begin
         r = rnd();
         rx_exp.push_back({2'b00, r[7:0]});
         m.send_char(EUSI_K_DATA, r[7:0]);
      end
      m.send_char(EUSI_K_EEP, 8'h00);
      rx_exp.push_back(10'h300);
      repeat (6) @(negedge clk_sys);
      check({15'h0, rx_pkt_ind}, 16'h0001);
      @(posedge clk_sys);
      #1 rx_rd_ready = 1'b1;
      foreach (rx_exp[j]) begin
         @(negedge clk_sys);
         check({5'h0, rx_rd_valid, rx_rd_err, rx_rd_end, rx_rd_data}, {6'h01, rx_exp[j]});
         @(posedge clk_sys);
         #1;
      end
      rx_rd_ready = 1'b0;
      @(negedge clk_sys);
      check({15'h0, rx_pkt_ind}, 16'h0000);
      // Incoming time-codes: only a count following the last one is indicated
      foreach (vals[j]) begin
         r = (rnd() & 32'hC0) | vals[j];
         m.send_char(EUSI_K_TIME, r[7:0]);
         if (vals[j] == ((last + 1) % 64)) ind_exp.push_back({2'd1, r[7:0]});
         last = vals[j];
      end
      ind_cmp();
      // Incoming interrupt twice, acknowledge it, then an incoming ack
      id = rnd() % 32;
      m.send_char(EUSI_K_INT, {3'h0, id});
      m.send_char(EUSI_K_INT, {3'h0, id});
      ind_exp.push_back({2'd2, 3'h0, id});
      ind_cmp();
      check({15'h0, sts_int_pend[id]}, 16'h0001);
      req(3, {3'h0, id}, 2'b00);
      exp_q.push_back({EUSI_K_ACK, 3'h0, id});
      drain();
      check({15'h0, sts_int_pend[id]}, 16'h0000);
      m.send_char(EUSI_K_ACK, {3'h0, id});
      ind_exp.push_back({2'd3, 3'h0, id});
      ind_cmp();
      // Loopback: a short packet returns into the receive buffer, link stays quiet
      @(posedge clk_sys);
      #1 cfg_loopback = 1'b1;
      r = rnd();
      req(0, r[7:0], 2'b00);
      req(0, 8'h00, 2'b01);
      repeat (4) @(negedge clk_sys);
      check({15'h0, rx_pkt_ind}, 16'h0001);
      check({8'h0, rx_rd_data}, {8'h0, r[7:0]});
      check(16'(m.got_q.size()), 16'h0000);
      @(posedge clk_sys);
      #1 rx_rd_ready = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 rx_rd_ready = 1'b0;
      cfg_loopback = 1'b0;
      @(negedge clk_sys);
      check({15'h0, rx_pkt_ind}, 16'h0000);
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
